// ==== pmsr_regs.sv ====
`timescale 1ns/1ps
module pmsr_regs
   import pmsr_pkg::*;
#(
   parameter int unsigned CNT_W = PMSR_CNT_W
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [PMSR_AW-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic loop1_pd_cycle_i,
   input wire logic loop1_in_window_i,
   input wire logic [CNT_W-1:0] loop1_lock_count_i,
   input wire logic loop2_pd_cycle_i,
   input wire logic loop2_in_window_i,
   input wire logic [CNT_W-1:0] loop2_lock_count_i,
   input wire logic loop2_reference_divider_i,
   output logic lock_status_pin_two_o,
   output logic lock_status_pin_two_oe_n_o,
   output logic loop2_powerdown_o,
   output logic loop2_prescaler_powerdown_o,
   output logic [7:0] fixed_config_a_o,
   output logic [7:0] fixed_config_b_o,
   output logic [7:0] oscillator_trim_a_o,
   output logic [7:0] oscillator_trim_b_o,
   output logic [1:0] lock_lost_o
);
   logic [4:0] lock_pin_one_source_select_ff;
   logic [4:0] lock_pin_two_source_select_ff;
   logic [2:0] lock_pin_two_io_type_ff;
   logic [7:0] fixed_config_a_ff;
   logic [7:0] fixed_config_b_ff;
   logic loop2_powerdown_ff;
   logic loop2_prescaler_powerdown_ff;
   logic [7:0] oscillator_trim_a_ff;
   logic [7:0] oscillator_trim_b_ff;
   logic [1:0] lost_clear_ff;
   logic [1:0] lock_lost_flag_ff;
   logic [1:0] lock_level_prev_ff;
   logic [1:0] lock_level;
   logic [7:0] rdata_ff;
   logic rvalid_ff;
   logic [7:0] nxt_rdata;
   logic refdiv_prev_ff;
   logic refdiv_half_ff;
   logic pin_level;
   logic nxt_pin_out;
   logic nxt_pin_oe_n;
   logic pin_out_ff;
   logic pin_oe_n_ff;
   logic refdiv_allowed;
   logic wr_pin_one;
   logic wr_pin_two;
   logic wr_fixed_a;
   logic wr_fixed_b;
   logic wr_pwr;
   logic wr_trim_a;
   logic wr_trim_b;
   logic [1:0] wr_status;

   if (CNT_W < 1 || CNT_W > 24)
   begin : g_cnt_w_check
      $error("lock count width out of range");
   end

   // Write strobes per register
   assign wr_pin_one = reg_wr_i && (reg_addr_i == PMSR_OFS_PIN_ONE);
   assign wr_pin_two = reg_wr_i && (reg_addr_i == PMSR_OFS_PIN_TWO);
   assign wr_fixed_a = reg_wr_i && (reg_addr_i == PMSR_OFS_FIXED_A);
   assign wr_fixed_b = reg_wr_i && (reg_addr_i == PMSR_OFS_FIXED_B);
   assign wr_pwr = reg_wr_i && (reg_addr_i == PMSR_OFS_PWR);
   assign wr_trim_a = reg_wr_i && (reg_addr_i == PMSR_OFS_TRIM_A);
   assign wr_trim_b = reg_wr_i && (reg_addr_i == PMSR_OFS_TRIM_B);
   assign wr_status[0] = reg_wr_i && (reg_addr_i == PMSR_OFS_LOOP1_ST);
   assign wr_status[1] = reg_wr_i && (reg_addr_i == PMSR_OFS_LOOP2_ST);

   // Lock pin source selects
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         lock_pin_one_source_select_ff <= PMSR_SRC_RST;
         lock_pin_two_source_select_ff <= PMSR_SRC_RST;
         lock_pin_two_io_type_ff <= PMSR_TYPE_RST; // RULE2
      end
      else
      begin
         if (wr_pin_one)
         begin
            lock_pin_one_source_select_ff <= reg_wdata_i[PMSR_SRC_LSB +: 5];
         end
         if (wr_pin_two)
         begin
            lock_pin_two_source_select_ff <= reg_wdata_i[PMSR_SRC_LSB +: 5];
            lock_pin_two_io_type_ff <= reg_wdata_i[PMSR_TYPE_LSB +: 3]; // RULE2
         end
      end
   end

   // Fixed configuration bytes
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         fixed_config_a_ff <= PMSR_FIXED_A_RST; // RULE4
         fixed_config_b_ff <= PMSR_FIXED_B_RST; // RULE5
      end
      else
      begin
         if (wr_fixed_a)
         begin
            fixed_config_a_ff <= reg_wdata_i;
         end
         if (wr_fixed_b)
         begin
            fixed_config_b_ff <= reg_wdata_i;
         end
      end
   end

   // Loop-2 power control, reserved bits dropped
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         loop2_prescaler_powerdown_ff <= PMSR_PWR_RST[PMSR_PRE_PD_BIT];
         loop2_powerdown_ff <= PMSR_PWR_RST[PMSR_PD_BIT];
      end
      else if (wr_pwr)
      begin
         loop2_prescaler_powerdown_ff <= reg_wdata_i[PMSR_PRE_PD_BIT]; // RULE6
         loop2_powerdown_ff <= reg_wdata_i[PMSR_PD_BIT]; // RULE7 RULE21
      end
   end

   // Oscillator trim bytes
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         oscillator_trim_a_ff <= PMSR_TRIM_RST;
         oscillator_trim_b_ff <= PMSR_TRIM_RST;
      end
      else
      begin
         if (wr_trim_a)
         begin
            oscillator_trim_a_ff <= reg_wdata_i; // RULE8
         end
         if (wr_trim_b)
         begin
            oscillator_trim_b_ff <= reg_wdata_i; // RULE9
         end
      end
   end

   // Per-loop lock detect, clear control and sticky lost flag
   for (genvar g = 0; g < 2; g++)
   begin : g_loop
      pmsr_lock_detect #(
         .CNT_W(CNT_W)
      ) u_detect (
         .core_clk_i(core_clk_i),
         .sys_rst_i(sys_rst_i),
         .pd_cycle_i((g == 0) ? loop1_pd_cycle_i : loop2_pd_cycle_i),
         .in_window_i((g == 0) ? loop1_in_window_i : loop2_in_window_i),
         .lock_count_i((g == 0) ? loop1_lock_count_i : loop2_lock_count_i),
         .lock_o(lock_level[g])
      );

      always_ff @(posedge core_clk_i or posedge sys_rst_i)
      begin
         if (sys_rst_i)
         begin
            lost_clear_ff[g] <= 1'b0;
         end
         else if (wr_status[g])
         begin
            lost_clear_ff[g] <= reg_wdata_i[PMSR_CLR_BIT]; // RULE14 RULE19
         end
      end

      always_ff @(posedge core_clk_i or posedge sys_rst_i)
      begin
         if (sys_rst_i)
         begin
            lock_level_prev_ff[g] <= 1'b0;
         end
         else
         begin
            lock_level_prev_ff[g] <= lock_level[g];
         end
      end

      // Clear holds the flag low; only a true falling edge sets it
      always_ff @(posedge core_clk_i or posedge sys_rst_i)
      begin
         if (sys_rst_i)
         begin
            lock_lost_flag_ff[g] <= 1'b0;
         end
         else if (lost_clear_ff[g])
         begin
            lock_lost_flag_ff[g] <= 1'b0; // RULE15 RULE19
         end
         else if (lock_level_prev_ff[g] && !lock_level[g])
         begin
            lock_lost_flag_ff[g] <= 1'b1; // RULE11 RULE12 RULE16 RULE17
         end
      end
   end

   // Divided reference for the pin-two half-rate source
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         refdiv_prev_ff <= 1'b0;
         refdiv_half_ff <= 1'b0;
      end
      else
      begin
         refdiv_prev_ff <= loop2_reference_divider_i;
         if (loop2_reference_divider_i && !refdiv_prev_ff)
         begin
            refdiv_half_ff <= !refdiv_half_ff;
         end
      end
   end

   assign refdiv_allowed = (lock_pin_one_source_select_ff != PMSR_SRC_LOOP2)
      && (lock_pin_one_source_select_ff != PMSR_SRC_BOTH); // RULE3

   // Pin-two level source
   always_comb
   begin
      case (lock_pin_two_source_select_ff)
         PMSR_SRC_LOOP1: pin_level = lock_level[0];
         PMSR_SRC_LOOP2: pin_level = lock_level[1];
         PMSR_SRC_BOTH: pin_level = lock_level[0] & lock_level[1];
         PMSR_SRC_REFDIV: pin_level = refdiv_allowed & loop2_reference_divider_i; // RULE3
         PMSR_SRC_REFDIV_HALF: pin_level = refdiv_allowed & refdiv_half_ff; // RULE3
         default: pin_level = 1'b0;
      endcase
   end

   // Pin-two drive type; reserved codes leave the pin released
   always_comb
   begin
      case (lock_pin_two_io_type_ff)
         PMSR_TYPE_PP:
         begin
            nxt_pin_out = pin_level; // RULE1
            nxt_pin_oe_n = 1'b0;
         end
         PMSR_TYPE_PP_INV:
         begin
            nxt_pin_out = !pin_level; // RULE1
            nxt_pin_oe_n = 1'b0;
         end
         PMSR_TYPE_OD:
         begin
            nxt_pin_out = 1'b0; // RULE1
            nxt_pin_oe_n = pin_level;
         end
         default:
         begin
            nxt_pin_out = 1'b0;
            nxt_pin_oe_n = 1'b1;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pin_out_ff <= 1'b0;
         pin_oe_n_ff <= 1'b1;
      end
      else
      begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_n_ff <= nxt_pin_oe_n;
      end
   end

   // Read decode; unmapped reads return zero
   always_comb
   begin
      nxt_rdata = 8'h00;
      if (reg_addr_i == PMSR_OFS_PIN_ONE)
      begin
         nxt_rdata[PMSR_SRC_LSB +: 5] = lock_pin_one_source_select_ff;
      end
      else if (reg_addr_i == PMSR_OFS_PIN_TWO)
      begin
         nxt_rdata[PMSR_SRC_LSB +: 5] = lock_pin_two_source_select_ff;
         nxt_rdata[PMSR_TYPE_LSB +: 3] = lock_pin_two_io_type_ff;
      end
      else if (reg_addr_i == PMSR_OFS_FIXED_A)
      begin
         nxt_rdata = fixed_config_a_ff;
      end
      else if (reg_addr_i == PMSR_OFS_FIXED_B)
      begin
         nxt_rdata = fixed_config_b_ff;
      end
      else if (reg_addr_i == PMSR_OFS_PWR)
      begin
         nxt_rdata[PMSR_PRE_PD_BIT] = loop2_prescaler_powerdown_ff; // RULE21
         nxt_rdata[PMSR_PD_BIT] = loop2_powerdown_ff;
      end
      else if (reg_addr_i == PMSR_OFS_TRIM_A)
      begin
         nxt_rdata = oscillator_trim_a_ff;
      end
      else if (reg_addr_i == PMSR_OFS_TRIM_B)
      begin
         nxt_rdata = oscillator_trim_b_ff;
      end
      else if (reg_addr_i == PMSR_OFS_LOOP1_ST)
      begin
         nxt_rdata[PMSR_LOST_BIT] = lock_lost_flag_ff[0]; // RULE11
         nxt_rdata[PMSR_LEVEL_BIT] = lock_level[0]; // RULE13
         nxt_rdata[PMSR_CLR_BIT] = lost_clear_ff[0];
      end
      else if (reg_addr_i == PMSR_OFS_LOOP2_ST)
      begin
         nxt_rdata[PMSR_LOST_BIT] = lock_lost_flag_ff[1]; // RULE16
         nxt_rdata[PMSR_LEVEL_BIT] = lock_level[1]; // RULE18
         nxt_rdata[PMSR_CLR_BIT] = lost_clear_ff[1];
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         rdata_ff <= 8'h00;
         rvalid_ff <= 1'b0;
      end
      else
      begin
         rvalid_ff <= reg_rd_i;
         if (reg_rd_i)
         begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign reg_rvalid_o = rvalid_ff;
   assign lock_status_pin_two_o = pin_out_ff;
   assign lock_status_pin_two_oe_n_o = pin_oe_n_ff;
   assign loop2_powerdown_o = loop2_powerdown_ff;
   assign loop2_prescaler_powerdown_o = loop2_prescaler_powerdown_ff;
   assign fixed_config_a_o = fixed_config_a_ff;
   assign fixed_config_b_o = fixed_config_b_ff;
   assign oscillator_trim_a_o = oscillator_trim_a_ff;
   assign oscillator_trim_b_o = oscillator_trim_b_ff;
   assign lock_lost_o = lock_lost_flag_ff;
endmodule

// ==== pmsr_pkg.sv ====
// Contract
// RULE1: Pin-two type code 3 push-pull, 4 inverted push-pull, 6 open drain.
// RULE2: Pin-two type field is bits 2:0, resets to 6; 0,1,2,5 reserved.
// RULE3: Loop-2 reference divider on pin two only when pin-one source not 2 or 3.
// RULE4: Software writes fixed byte A with 0xAA; it resets to 0x0A.
// RULE5: Software writes fixed byte B with 0x02; it resets to zero.
// RULE6: Power control bit 6 set powers down the loop-2 prescaler.
// RULE7: Power control bit 5 set powers down the whole second loop.
// RULE8: Software writes 21 into oscillator trim A at 0x17C.
// RULE9: Software writes 51 into oscillator trim B at 0x17D.
// RULE10: Both trim bytes are written before 0x168 when the high band is used.
// RULE11: Loop-1 lock-lost flag, bit 2, sets on a falling lock detect edge.
// RULE12: Loop-1 flag cleared while detect is low waits for a later fall.
// RULE13: Loop-1 status bit 1 reads the live loop-1 lock detect level.
// RULE14: Software clears the loop-1 flag by writing bit 0 one then zero.
// RULE15: Loop-1 clear bit at one forces the flag low; zero arms it.
// RULE16: Loop-2 lock-lost flag, bit 2, sets on a falling lock detect edge.
// RULE17: Loop-2 flag cleared while detect is low waits for a later fall.
// RULE18: Loop-2 status bit 1 reads the live loop-2 lock detect level.
// RULE19: Loop-2 clear bit 0 written one then zero; at one flag held low.
// RULE20: Lock detect asserts after count in-window cycles; excursion resets count.
// RULE21: Reserved status and power control bits read zero and ignore writes.
package pmsr_pkg;
   localparam int unsigned PMSR_AW = 13;
   localparam logic [12:0] PMSR_OFS_PIN_ONE = 13'h016C;
   localparam logic [12:0] PMSR_OFS_PIN_TWO = 13'h016E;
   localparam logic [12:0] PMSR_OFS_FIXED_A = 13'h0171;
   localparam logic [12:0] PMSR_OFS_FIXED_B = 13'h0172;
   localparam logic [12:0] PMSR_OFS_PWR = 13'h0173;
   localparam logic [12:0] PMSR_OFS_TRIM_A = 13'h017C;
   localparam logic [12:0] PMSR_OFS_TRIM_B = 13'h017D;
   localparam logic [12:0] PMSR_OFS_LOOP1_ST = 13'h0182;
   localparam logic [12:0] PMSR_OFS_LOOP2_ST = 13'h0183;
   localparam int unsigned PMSR_TYPE_LSB = 0;
   localparam int unsigned PMSR_SRC_LSB = 3;
   localparam int unsigned PMSR_PRE_PD_BIT = 6;
   localparam int unsigned PMSR_PD_BIT = 5;
   localparam int unsigned PMSR_LOST_BIT = 2;
   localparam int unsigned PMSR_LEVEL_BIT = 1;
   localparam int unsigned PMSR_CLR_BIT = 0;
   localparam logic [2:0] PMSR_TYPE_RST = 3'h6;
   localparam logic [4:0] PMSR_SRC_RST = 5'h00;
   localparam logic [7:0] PMSR_FIXED_A_RST = 8'h0A;
   localparam logic [7:0] PMSR_FIXED_B_RST = 8'h00;
   localparam logic [7:0] PMSR_PWR_RST = 8'h00;
   localparam logic [7:0] PMSR_TRIM_RST = 8'h00;
   localparam logic [2:0] PMSR_TYPE_PP = 3'h3;
   localparam logic [2:0] PMSR_TYPE_PP_INV = 3'h4;
   localparam logic [2:0] PMSR_TYPE_OD = 3'h6;
   localparam logic [4:0] PMSR_SRC_LOW = 5'h00;
   localparam logic [4:0] PMSR_SRC_LOOP1 = 5'h01;
   localparam logic [4:0] PMSR_SRC_LOOP2 = 5'h02;
   localparam logic [4:0] PMSR_SRC_BOTH = 5'h03;
   localparam logic [4:0] PMSR_SRC_REFDIV = 5'h11;
   localparam logic [4:0] PMSR_SRC_REFDIV_HALF = 5'h12;
   localparam int unsigned PMSR_CNT_W = 14;
endpackage

// ==== pmsr_lock_detect.sv ====
`timescale 1ns/1ps
module pmsr_lock_detect
   import pmsr_pkg::*;
#(
   parameter int unsigned CNT_W = PMSR_CNT_W
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic pd_cycle_i,
   input wire logic in_window_i,
   input wire logic [CNT_W-1:0] lock_count_i,
   output logic lock_o
);
   logic [CNT_W-1:0] run_ff;
   logic lock_ff;

   if (CNT_W < 1 || CNT_W > 24)
   begin : g_cnt_w_check
      $error("lock detect counter width out of range");
   end

   // Consecutive in-window phase detector cycles, cleared on excursion
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         run_ff <= '0;
         lock_ff <= 1'b0;
      end
      else if (pd_cycle_i)
      begin
         if (!in_window_i)
         begin
            run_ff <= '0; // RULE20
            lock_ff <= 1'b0;
         end
         else
         begin
            if (run_ff < lock_count_i)
            begin
               run_ff <= run_ff + 1'b1;
            end
            lock_ff <= (run_ff >= lock_count_i) || ((run_ff + 1'b1) == lock_count_i); // RULE20
         end
      end
   end

   assign lock_o = lock_ff;
endmodule

// ==== pmsr_regs_props.sv ====
`timescale 1ns/1ps
module pmsr_regs_props
   import pmsr_pkg::*;
#(
   parameter int unsigned CNT_W = PMSR_CNT_W
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [PMSR_AW-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic loop1_pd_cycle_i,
   input wire logic loop1_in_window_i,
   input wire logic [CNT_W-1:0] loop1_lock_count_i,
   input wire logic loop2_pd_cycle_i,
   input wire logic loop2_in_window_i,
   input wire logic [CNT_W-1:0] loop2_lock_count_i,
   input wire logic loop2_reference_divider_i,
   input wire logic lock_status_pin_two_o,
   input wire logic lock_status_pin_two_oe_n_o,
   input wire logic loop2_powerdown_o,
   input wire logic loop2_prescaler_powerdown_o,
   input wire logic [7:0] fixed_config_a_o,
   input wire logic [7:0] fixed_config_b_o,
   input wire logic [7:0] oscillator_trim_a_o,
   input wire logic [7:0] oscillator_trim_b_o,
   input wire logic [1:0] lock_lost_o
);
   logic [2:0] type_ff;
   logic [1:0] clr_ff;
   logic [1:0] fall_w;
   assign fall_w = {loop2_pd_cycle_i & ~loop2_in_window_i, loop1_pd_cycle_i & ~loop1_in_window_i};
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // Mirrors of pin-two type and clear controls
   always_ff @(posedge core_clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         type_ff <= PMSR_TYPE_RST;
         clr_ff <= 2'h0;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == PMSR_OFS_PIN_TWO)
            type_ff <= reg_wdata_i[2:0];
         if (reg_addr_i == PMSR_OFS_LOOP1_ST)
            clr_ff[0] <= reg_wdata_i[0];
         if (reg_addr_i == PMSR_OFS_LOOP2_ST)
            clr_ff[1] <= reg_wdata_i[0];
      end
   end
   loop_down_a: assert property (
      reg_wr_i && reg_addr_i == PMSR_OFS_PWR |=> loop2_powerdown_o == $past(reg_wdata_i[5]))
      else $error("loop-2 powerdown does not follow bit 5");
   pre_down_a: assert property (
      reg_wr_i && reg_addr_i == PMSR_OFS_PWR
      |=> loop2_prescaler_powerdown_o == $past(reg_wdata_i[6]))
      else $error("prescaler powerdown does not follow bit 6");
   od_low_a: assert property (
      type_ff == PMSR_TYPE_OD && $stable(type_ff) |-> !lock_status_pin_two_o)
      else $error("open drain pin drives high");
   pp_drive_a: assert property (
      type_ff inside {3'h3, 3'h4} && $stable(type_ff) |-> !lock_status_pin_two_oe_n_o)
      else $error("push-pull pin not driven");
   rsvd_release_a: assert property (
      type_ff inside {3'h0, 3'h1, 3'h2, 3'h5} && $stable(type_ff) |-> lock_status_pin_two_oe_n_o)
      else $error("reserved pin type drives");
   lost_cause_one_a: assert property (
      $rose(lock_lost_o[0]) |-> $past(fall_w[0], 2) && !$past(clr_ff[0]))
      else $error("loop-1 lost flag set without a fall");
   lost_cause_two_a: assert property (
      $rose(lock_lost_o[1]) |-> $past(fall_w[1], 2) && !$past(clr_ff[1]))
      else $error("loop-2 lost flag set without a fall");
   clr_hold_one_a: assert property (clr_ff[0] |=> !lock_lost_o[0])
      else $error("loop-1 lost flag not held clear");
   clr_hold_two_a: assert property (clr_ff[1] |=> !lock_lost_o[1])
      else $error("loop-2 lost flag not held clear");
   cover property ($rose(lock_lost_o[0]));
   cover property ($rose(lock_lost_o[1]));
   cover property (reg_rvalid_o && reg_rdata_o[1]);
   cover property (!lock_status_pin_two_oe_n_o && lock_status_pin_two_o);
endmodule

bind pmsr_regs pmsr_regs_props #(.CNT_W(CNT_W)) pmsr_regs_props_i (.core_clk_i, .sys_rst_i,
   .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
   .loop1_pd_cycle_i, .loop1_in_window_i, .loop1_lock_count_i, .loop2_pd_cycle_i,
   .loop2_in_window_i, .loop2_lock_count_i, .loop2_reference_divider_i,
   .lock_status_pin_two_o, .lock_status_pin_two_oe_n_o, .loop2_powerdown_o,
   .loop2_prescaler_powerdown_o, .fixed_config_a_o, .fixed_config_b_o,
   .oscillator_trim_a_o, .oscillator_trim_b_o, .lock_lost_o);

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
   import pmsr_pkg::*;
;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [PMSR_AW-1:0] reg_addr_i = 13'h0000;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic loop1_pd_cycle_i = 1'b0;
   logic loop1_in_window_i = 1'b0;
   logic [13:0] loop1_lock_count_i = 14'h0002;
   logic loop2_pd_cycle_i = 1'b0;
   logic loop2_in_window_i = 1'b0;
   logic [13:0] loop2_lock_count_i = 14'h0002;
   logic loop2_reference_divider_i = 1'b0;
   logic lock_status_pin_two_o;
   logic lock_status_pin_two_oe_n_o;
   logic loop2_powerdown_o;
   logic loop2_prescaler_powerdown_o;
   logic [7:0] fixed_config_a_o;
   logic [7:0] fixed_config_b_o;
   logic [7:0] oscillator_trim_a_o;
   logic [7:0] oscillator_trim_b_o;
   logic [1:0] lock_lost_o;
   int error_cnt = 0;
   int checks = 0;
   logic [12:0] adr [4] = '{13'h0171, 13'h0172, 13'h017C, 13'h017D};
   logic [7:0] rstv [4] = '{8'h0A, 8'h00, 8'h00, 8'h00};
   logic [7:0] val [4] = '{8'hAA, 8'h02, 8'h15, 8'h33};
   logic [7:0] pw [4] = '{8'hFF, 8'h20, 8'h40, 8'h00};
   logic [7:0] src1 [3] = '{8'h10, 8'h18, 8'h00};
   logic [7:0] src2 [4] = '{8'h1B, 8'h0B, 8'h1B, 8'h03};
   logic [7:0] e;

   pmsr_regs pmsr_regs_i (.core_clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
      .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .loop1_pd_cycle_i, .loop1_in_window_i,
      .loop1_lock_count_i, .loop2_pd_cycle_i, .loop2_in_window_i, .loop2_lock_count_i,
      .loop2_reference_divider_i, .lock_status_pin_two_o, .lock_status_pin_two_oe_n_o,
      .loop2_powerdown_o, .loop2_prescaler_powerdown_o, .fixed_config_a_o,
      .fixed_config_b_o, .oscillator_trim_a_o, .oscillator_trim_b_o, .lock_lost_o);

   always #10 core_clk_i = ~core_clk_i;

   task automatic wrap_up();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] x, input string m);
      checks++;
      if (g !== x)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
   endtask

   // Read one byte, waiting a bounded time for the valid pulse
   task automatic rd(input logic [12:0] a, input logic [7:0] x);
      @(negedge core_clk_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge core_clk_i);
      reg_rd_i = 1'b0;
      for (int n = 0; n < 3 && reg_rvalid_o !== 1'b1; n++)
         @(negedge core_clk_i);
      chk({7'h00, reg_rvalid_o}, 8'h01, "read valid");
      chk(reg_rdata_o, x, "read data");
   endtask

   // One phase-detector cycle on a loop
   task automatic pd(input int lp, input logic w);
      @(negedge core_clk_i);
      loop1_pd_cycle_i = (lp == 1);
      loop2_pd_cycle_i = (lp == 2);
      loop1_in_window_i = w;
      loop2_in_window_i = w;
      @(negedge core_clk_i);
      loop1_pd_cycle_i = 1'b0;
      loop2_pd_cycle_i = 1'b0;
   endtask

   task automatic lock_seq(input int lp);
      logic [12:0] a;
      a = (lp == 1) ? PMSR_OFS_LOOP1_ST : PMSR_OFS_LOOP2_ST;
      pd(lp, 1'b1);
      rd(a, 8'h00);
      pd(lp, 1'b0);
      pd(lp, 1'b1);
      rd(a, 8'h00);
      pd(lp, 1'b1);
      rd(a, 8'h02);
      pd(lp, 1'b0);
      rd(a, 8'h04);
      chk({7'h00, lock_lost_o[lp-1]}, 8'h01, "lost pin");
      wr(a, 8'h01);
      rd(a, 8'h01);
      wr(a, 8'hF8);
      rd(a, 8'h00);
      pd(lp, 1'b1);
      pd(lp, 1'b1);
      wr(a, 8'h01);
      pd(lp, 1'b0);
      rd(a, 8'h01);
      wr(a, 8'h00);
      rd(a, 8'h00);
      pd(lp, 1'b1);
      pd(lp, 1'b1);
      pd(lp, 1'b0);
      rd(a, 8'h04);
      wr(a, 8'h01);
      wr(a, 8'h00);
   endtask

   initial
   begin
      #50us;
      error_cnt++;
      wrap_up();
   end

   initial
   begin
      repeat (10) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      for (int i = 0; i < 4; i++)
         rd(adr[i], rstv[i]);
      rd(PMSR_OFS_PIN_TWO, 8'h06);
      rd(PMSR_OFS_PWR, 8'h00);
      rd(13'h1FF0, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(adr[i], val[i]);
         rd(adr[i], val[i]);
      end
      chk(fixed_config_a_o, 8'hAA, "fixed a");
      chk(fixed_config_b_o, 8'h02, "fixed b");
      chk(oscillator_trim_a_o, 8'h15, "trim a");
      chk(oscillator_trim_b_o, 8'h33, "trim b");
      wr(13'h0168, 8'h5A);
      rd(13'h0168, 8'h00);
      chk(oscillator_trim_a_o, 8'h15, "trim a kept");
      for (int i = 0; i < 4; i++)
      begin
         wr(PMSR_OFS_PWR, pw[i]);
         chk({7'h00, loop2_powerdown_o}, {7'h00, pw[i][5]}, "loop down");
         chk({7'h00, loop2_prescaler_powerdown_o}, {7'h00, pw[i][6]}, "pre down");
         rd(PMSR_OFS_PWR, pw[i] & 8'h60);
      end
      lock_seq(1);
      lock_seq(2);
      for (int l = 0; l < 2; l++)
      begin
         pd(2, l[0]);
         pd(2, l[0]);
         for (int t = 0; t < 7; t++)
         begin
            wr(PMSR_OFS_PIN_TWO, 8'h10 | t[7:0]);
            repeat (2) @(negedge core_clk_i);
            e = (t == 3 || t == 4) ? 8'h00 : ((t == 6) ? {7'h00, l[0]} : 8'h01);
            chk({7'h00, lock_status_pin_two_oe_n_o}, e, "pin enable");
            e = (t == 3) ? {7'h00, l[0]} : ((t == 4) ? {7'h00, ~l[0]} : 8'h00);
            if (t == 3 || t == 4 || t == 6)
               chk({7'h00, lock_status_pin_two_o}, e, "pin value");
         end
      end
      loop2_reference_divider_i = 1'b1;
      wr(PMSR_OFS_PIN_TWO, 8'h8B);
      for (int i = 0; i < 3; i++)
      begin
         wr(PMSR_OFS_PIN_ONE, src1[i]);
         repeat (2) @(negedge core_clk_i);
         chk({7'h00, lock_status_pin_two_o}, {7'h00, src1[i] == 8'h00}, "ref div");
      end
      // Half-rate divider source toggles on each rising divider edge
      wr(PMSR_OFS_PIN_TWO, 8'h93);
      repeat (2) @(negedge core_clk_i);
      chk({7'h00, lock_status_pin_two_o}, 8'h01, "half ref");
      loop2_reference_divider_i = 1'b0;
      @(negedge core_clk_i);
      loop2_reference_divider_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      chk({7'h00, lock_status_pin_two_o}, 8'h00, "half ref");
      // Lock sources on pin two: both, loop 1 alone, constant low
      for (int i = 0; i < 4; i++)
      begin
         if (i == 1)
         begin
            pd(1, 1'b1);
            pd(1, 1'b1);
         end
         wr(PMSR_OFS_PIN_TWO, src2[i]);
         repeat (2) @(negedge core_clk_i);
         chk({7'h00, lock_status_pin_two_o}, {7'h00, i == 1 || i == 2}, "pin source");
      end
      wrap_up();
   end
endmodule
